//--- design/ljp_regs.vh
// ljp_regs.vh: offsets, fields, reset values and timing counts of the jam stage
// assumes a 32-bit classic wishbone slave, byte addresses, 20 MHz clock
`ifndef LJP_REGS_VH
`define LJP_REGS_VH

// register byte offsets
`define LJP_CTRL_OFS      8'h00
`define LJP_PICKUP_OFS    8'h04
`define LJP_DELAY_OFS     8'h08
`define LJP_HOTLIM_OFS    8'h0c
`define LJP_STALL_OFS     8'h10
`define LJP_CURR_OFS      8'h14
`define LJP_THETA_OFS     8'h18
`define LJP_STATUS_OFS    8'h1c
`define LJP_RATIO_OFS     8'h20
`define LJP_EXPECT_OFS    8'h24
`define LJP_REMAIN_OFS    8'h28
`define LJP_IRQ_STAT_OFS  8'h2c
`define LJP_IRQ_MASK_OFS  8'h30

// ctrl fields
`define LJP_CTRL_EN_BIT     0
`define LJP_CTRL_COLD_BIT   1

// status fields
`define LJP_ST_COND_LO      0
`define LJP_ST_HOT_BIT      2
`define LJP_ST_PICKUP_BIT   3

// condition codes
`define LJP_COND_NORMAL   2'h0
`define LJP_COND_START    2'h1
`define LJP_COND_TRIP     2'h2
`define LJP_COND_BLOCKED  2'h3

// irq bits
`define LJP_IRQ_START_BIT   0
`define LJP_IRQ_TRIP_BIT    1
`define LJP_IRQ_BLOCK_BIT   2

// reset values (current in 0.01 xIn, theta in 0.1 %, times in 0.1 s / 5 ms)
`define LJP_PICKUP_RST    16'h0258
`define LJP_HOTLIM_RST    16'h02bc
`define LJP_COLD_RST      16'h00c8
`define LJP_HOT_RST       16'h0096
`define LJP_DELAY_RST     20'h000c8
`define LJP_CTRL_RST      2'h1

// timing
`define LJP_TICK_NS       5000000
`define LJP_CLK_NS        50
`define LJP_TICK_CYC      (`LJP_TICK_NS / `LJP_CLK_NS)
`define LJP_BLOCK_LEAD_MS 5

`endif

//--- design/ljp_stage.v
// ljp_stage.v: load jam protection stage with a wishbone register file
// assumes synchronous inputs on clk_i, current and theta given by the front end
// Function
// [RULE1] hot curve when theta above limit
// [RULE2] otherwise cold curve scaled by theta
// [RULE3] unset cold stall time uses hot
// [RULE4] expose current to pickup ratio, 0.01
// [RULE5] fixed definite time delay to trip
// [RULE6] count down remaining time, 5 ms
// [RULE7] expose expected time, recompute on change
// [RULE8] sample block at start of cycle
// [RULE9] pickup unblocked gives start and timing
// [RULE10] pickup blocked gives blocked, no timing
// [RULE11] late block clears start, releases
// [RULE12] block source leads delay by 5 ms
// [RULE13] condition normal, start, trip, blocked
// [RULE14] pickup when current exceeds setting
// [RULE15] trip when countdown ends, unblocked
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ljp_regs.vh"

module ljp_stage #(
  parameter TICK_CYC = `LJP_TICK_CYC
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output wire        err_o,
  // front end and blocking matrix
  input  wire [15:0] highest_phase_current_i,
  input  wire [15:0] theta_used_i,
  input  wire        block_i,
  // protection outputs
  output reg         start_o,
  output reg         trip_o,
  output reg         blocked_o,
  output reg         hot_curve_o,
  output reg  [23:0] stall_time_o,
  output wire        irq_o
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  localparam S_NORMAL  = 2'h0;
  localparam S_START   = 2'h1;
  localparam S_TRIP    = 2'h2;
  localparam S_BLOCKED = 2'h3;

  reg  [1:0]  ctrl;
  reg  [15:0] pickup_current_setting;
  reg  [19:0] definite_time_delay;
  reg  [15:0] hot_limit;
  reg  [15:0] stall_cold;
  reg  [15:0] stall_hot;
  reg  [1:0]  state;
  reg  [19:0] remain;
  reg  [19:0] expect_time;
  reg  [15:0] ratio;
  reg  [2:0]  irq_stat;
  reg  [2:0]  irq_mask;
  reg  [22:0] tick_cnt;
  reg         tick;
  reg         block_s;
  reg  [15:0] last_current;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req    = cyc_i & stb_i & ~ack_o;
  // write lands on the edge that samples ack
  wire wr     = cyc_i & stb_i & ack_o & we_i & (sel_i == 4'hf);
  wire mapped = (adr_i[1:0] == 2'h0) && (adr_i <= `LJP_IRQ_MASK_OFS);
  assign err_o = 1'b0;

  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = wr && mapped && (adr_i == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // program cycle tick and block sample
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 23'h000000;
      tick     <= 1'b0;
      block_s  <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYC - 1);
      if (tick_cnt == TICK_CYC - 1)
        tick_cnt <= 23'h000000;
      else
        tick_cnt <= tick_cnt + 23'h000001;
      // [RULE8] block at cycle start
      if (tick_cnt == TICK_CYC - 1)
        block_s <= block_i;
    end
  end

  // ----------------------------------------------------------------
  // pickup, ratio, curve
  // ----------------------------------------------------------------
  // [RULE14] current above setting
  wire pickup = ctrl[`LJP_CTRL_EN_BIT] &&
                (highest_phase_current_i > pickup_current_setting);
  // [RULE3] cold defaults to hot
  wire [15:0] cold_eff = ctrl[`LJP_CTRL_COLD_BIT] ? stall_cold : stall_hot;
  wire [31:0] ratio_full;
  wire [31:0] cold_scaled;
  wire [31:0] cold_div;
  // [RULE4] ratio in hundredths
  assign ratio_full = (pickup_current_setting == 16'h0000) ? 32'h0000ffff :
                      ({16'h0000, highest_phase_current_i} * 32'd100) /
                      {16'h0000, pickup_current_setting};
  // [RULE2] cold scaled by theta
  assign cold_scaled = {16'h0000, cold_eff} *
                       ({16'h0000, 16'd1000} - {16'h0000, theta_used_i});
  // full-width quotient, no overflow
  assign cold_div = cold_scaled / 32'd1000;

  always @(posedge clk_i) begin
    if (rst_i) begin
      hot_curve_o  <= 1'b0;
      stall_time_o <= 24'h000000;
      ratio        <= 16'h0000;
    end else begin
      ratio <= (ratio_full > 32'h0000ffff) ? 16'hffff : ratio_full[15:0];
      // [RULE1] hot above limit
      hot_curve_o <= (theta_used_i > hot_limit);
      if (theta_used_i > hot_limit)
        stall_time_o <= {stall_hot, 8'h00} / 24'd1;
      else if (theta_used_i >= 16'd1000)
        stall_time_o <= 24'h000000;
      else
        stall_time_o <= {cold_div[15:0], 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // condition state machine and timing
  // ----------------------------------------------------------------
  reg [1:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      S_NORMAL: begin
        // [RULE9] unblocked start
        if (pickup && !block_s)
          next_state = S_START;
        // [RULE10] blocked pickup
        else if (pickup && block_s)
          next_state = S_BLOCKED;
      end
      S_START: begin
        // [RULE11] late block resets
        if (!pickup || block_s)
          next_state = S_NORMAL;
        // [RULE15] countdown end trips
        else if (tick && remain <= 20'h00001)
          next_state = S_TRIP;
      end
      S_TRIP: begin
        if (!pickup || block_s)
          next_state = S_NORMAL;
      end
      S_BLOCKED: begin
        if (!pickup)
          next_state = S_NORMAL;
        else if (!block_s)
          next_state = S_START;
      end
      default: next_state = S_NORMAL;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state        <= S_NORMAL;
      remain       <= 20'h00000;
      expect_time  <= 20'h00000;
      last_current <= 16'h0000;
    end else begin
      state        <= next_state;
      last_current <= highest_phase_current_i;
      // [RULE7] expected time refreshed
      if (state == S_NORMAL || highest_phase_current_i != last_current)
        expect_time <= definite_time_delay;
      // [RULE5] fixed delay load
      if (next_state == S_START && state != S_START)
        remain <= definite_time_delay;
      // [RULE6] 5 ms countdown
      else if (state == S_START && tick && remain != 20'h00000)
        remain <= remain - 20'h00001;
      else if (next_state == S_NORMAL)
        remain <= 20'h00000;
    end
  end

  // [RULE13] three outputs encode the four conditions
  always @(posedge clk_i) begin
    if (rst_i) begin
      start_o   <= 1'b0;
      trip_o    <= 1'b0;
      blocked_o <= 1'b0;
    end else begin
      start_o   <= (next_state == S_START) || (next_state == S_TRIP);
      trip_o    <= (next_state == S_TRIP);
      blocked_o <= (next_state == S_BLOCKED);
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  wire [2:0] ev;
  assign ev[`LJP_IRQ_START_BIT] = (next_state == S_START) && (state != S_START) &&
                                  (state != S_TRIP);
  assign ev[`LJP_IRQ_TRIP_BIT]  = (next_state == S_TRIP) && (state != S_TRIP);
  assign ev[`LJP_IRQ_BLOCK_BIT] = (next_state == S_BLOCKED) && (state != S_BLOCKED);
  assign irq_o = |(irq_stat & irq_mask);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
      always @(posedge clk_i) begin
        if (rst_i)
          irq_stat[gi] <= 1'b0;
        else if (ev[gi])
          irq_stat[gi] <= 1'b1;
        else if (wr_hit(`LJP_IRQ_STAT_OFS) && dat_i[gi])
          irq_stat[gi] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl                   <= `LJP_CTRL_RST;
      pickup_current_setting <= `LJP_PICKUP_RST;
      definite_time_delay    <= `LJP_DELAY_RST;
      hot_limit              <= `LJP_HOTLIM_RST;
      stall_cold             <= `LJP_COLD_RST;
      stall_hot              <= `LJP_HOT_RST;
      irq_mask               <= 3'h0;
      ack_o                  <= 1'b0;
      dat_o                  <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (wr_hit(`LJP_CTRL_OFS))
        ctrl <= dat_i[1:0];
      if (wr_hit(`LJP_PICKUP_OFS))
        pickup_current_setting <= dat_i[15:0];
      if (wr_hit(`LJP_DELAY_OFS))
        definite_time_delay <= dat_i[19:0];
      if (wr_hit(`LJP_HOTLIM_OFS))
        hot_limit <= dat_i[15:0];
      if (wr_hit(`LJP_STALL_OFS)) begin
        stall_cold <= dat_i[15:0];
        stall_hot  <= dat_i[31:16];
      end
      if (wr_hit(`LJP_IRQ_MASK_OFS))
        irq_mask <= dat_i[2:0];
      if (req && !we_i) begin
        case (adr_i)
          `LJP_CTRL_OFS:     dat_o <= {30'h00000000, ctrl};
          `LJP_PICKUP_OFS:   dat_o <= {16'h0000, pickup_current_setting};
          `LJP_DELAY_OFS:    dat_o <= {12'h000, definite_time_delay};
          `LJP_HOTLIM_OFS:   dat_o <= {16'h0000, hot_limit};
          `LJP_STALL_OFS:    dat_o <= {stall_hot, stall_cold};
          `LJP_CURR_OFS:     dat_o <= {16'h0000, highest_phase_current_i};
          `LJP_THETA_OFS:    dat_o <= {16'h0000, theta_used_i};
          `LJP_STATUS_OFS:   dat_o <= {28'h0000000, pickup, hot_curve_o, state};
          `LJP_RATIO_OFS:    dat_o <= {16'h0000, ratio};
          `LJP_EXPECT_OFS:   dat_o <= {12'h000, expect_time};
          `LJP_REMAIN_OFS:   dat_o <= {12'h000, remain};
          `LJP_IRQ_STAT_OFS: dat_o <= {29'h00000000, irq_stat};
          `LJP_IRQ_MASK_OFS: dat_o <= {29'h00000000, irq_mask};
          default:           dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ljp_stage

`default_nettype wire

//--- dv/ljp_stage_properties.sv
// ljp_stage_properties.sv: port assertions of the jam stage
// assumes one clock, sync high reset, bound onto ljp_stage
`timescale 1ns/10ps
`default_nettype none
module ljp_props #(
  parameter TICK_CYC = 10
) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  // protection
  input wire logic block_i,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o
);
  // ----------------
  // checks
  // ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // cycles since block_i was last seen high
  logic [31:0] blk_age;
  always @(posedge clk_i) begin
    if (rst_i)
      blk_age <= 32'hffffffff;
    else if (block_i)
      blk_age <= 32'h00000000;
    else if (blk_age != 32'hffffffff)
      blk_age <= blk_age + 32'h00000001;
  end
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  AST_ERR_ZERO: assert property (!err_o)
    else $error("err raised");
  AST_TRIP_IN_START: assert property (trip_o |-> start_o)
    else $error("trip without start");
  AST_START_XOR_BLK: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  AST_TRIP_FROM_START: assert property ($rose(trip_o) |-> $past(start_o))
    else $error("trip not preceded by start");
  AST_BLK_FROM_IN: assert property ($rose(blocked_o) |-> blk_age <= TICK_CYC + 1)
    else $error("blocked without block input");
  AST_RESET_QUIET: assert property ($past(rst_i) |-> !start_o && !trip_o && !blocked_o)
    else $error("outputs not cleared by reset");
endmodule // ljp_props
bind ljp_stage ljp_props #(.TICK_CYC(TICK_CYC)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .err_o(err_o), .block_i(block_i), .start_o(start_o),
  .trip_o(trip_o), .blocked_o(blocked_o)
);
`default_nettype wire

//--- dv/ljp_front_end.sv
// ljp_front_end.sv: current front end and blocking matrix model
// assumes requests from the bench, hands them on one edge later
`timescale 1ns/10ps
`default_nettype none
module ljp_front_end (
  input wire logic         clk_i,
  input wire logic [15:0]  cur_i,
  input wire logic [15:0]  theta_i,
  input wire logic         blk_i,
  output logic     [15:0]  cur_o = 16'h0000,
  output logic     [15:0]  theta_o = 16'h0000,
  output logic             blk_o = 1'b0
);
  always @(posedge clk_i) begin
    cur_o <= cur_i;
    theta_o <= theta_i;
    blk_o <= blk_i;
  end
endmodule // ljp_front_end
`default_nettype wire

//--- dv/ljp_stage_test.sv
// ljp_stage_test.sv: self-checking bench of the jam stage
// assumes ljp_stage with TICK_CYC 10 and the front end model
`timescale 1ns/10ps
`default_nettype none
module ljp_stage_test;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, r;
  logic ack_o, err_o, start_o, trip_o, blocked_o, hot_curve_o, irq_o;
  logic [15:0] cur_rq = 16'h0, th_rq = 16'h0, cur, th;
  logic blk_rq = 0, blk;
  logic [23:0] stall_time_o;
  logic [2:0] cond;
  assign cond = {blocked_o, trip_o, start_o};
  int mismatches = 0, n_compared = 0, cnt = 0, t0, n;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) cnt <= cnt + 1;
  ljp_front_end i_fe (.clk_i(clk_i), .cur_i(cur_rq), .theta_i(th_rq), .blk_i(blk_rq),
    .cur_o(cur), .theta_o(th), .blk_o(blk));
  ljp_stage #(.TICK_CYC(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .highest_phase_current_i(cur),
    .theta_used_i(th), .block_i(blk), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .hot_curve_o(hot_curve_o), .stall_time_o(stall_time_o),
    .irq_o(irq_o));
  // ----------------
  // helpers
  // ----------------
  task wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) begin
        r = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        return;
      end
    end
    mismatches++;
    wrap_up();
  endtask
  task await(input int k, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      if (cond[k] === v)
        return;
    end
    mismatches++;
    wrap_up();
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_reset;
    bus(0, 8'h00, 0);
    check(r, 32'h1);
    bus(0, 8'h04, 0);
    check(r, 32'h258);
    bus(0, 8'h08, 0);
    check(r, 32'hc8);
    bus(0, 8'h0c, 0);
    check(r, 32'h2bc);
    bus(0, 8'h10, 0);
    check(r, 32'h009600c8);
    bus(0, 8'h30, 0);
    check(r, 32'h0);
    bus(0, 8'h40, 0);
    check(r, 32'h0);
  endtask
  task t_curve;
    th_rq <= 16'h0320;
    repeat (5) @(posedge clk_i);
    check(hot_curve_o, 1);
    check(stall_time_o, 24'h009600);
    th_rq <= 16'h02bc;
    repeat (5) @(posedge clk_i);
    check(hot_curve_o, 0);
    check(stall_time_o, 24'h002d00);
    bus(1, 8'h00, 32'h3);
    th_rq <= 16'h01f4;
    repeat (5) @(posedge clk_i);
    check(stall_time_o, 24'h006400);
    bus(1, 8'h00, 32'h1);
    th_rq <= 16'h0000;
  endtask
  task t_trip;
    bus(1, 8'h08, 32'h14);
    bus(1, 8'h30, 32'h2);
    cur_rq <= 16'h04b0;
    await(0, 1, 20);
    t0 = cnt;
    bus(0, 8'h20, 0);
    check(r, 32'hc8);
    bus(0, 8'h28, 0);
    check(r <= 20 && r >= 18, 1);
    cur_rq <= 16'h0384;
    repeat (3) @(posedge clk_i);
    bus(0, 8'h24, 0);
    check(r, 32'h14);
    bus(0, 8'h20, 0);
    check(r, 32'h96);
    bus(0, 8'h1c, 0);
    check(r, 32'h9);
    check(irq_o, 0);
    await(1, 1, 250);
    check(cnt - t0 >= 185 && cnt - t0 <= 215, 1);
    bus(0, 8'h1c, 0);
    check(r, 32'ha);
    check(irq_o, 1);
    cur_rq <= 16'h0000;
    await(0, 0, 20);
    bus(1, 8'h2c, 32'h7);
    bus(0, 8'h2c, 0);
    check(r, 32'h0);
    check(irq_o, 0);
  endtask
  task t_block;
    blk_rq <= 1;
    repeat (25) @(posedge clk_i);
    cur_rq <= 16'h04b0;
    await(2, 1, 20);
    bus(0, 8'h1c, 0);
    check(r, 32'hb);
    repeat (300) @(posedge clk_i);
    check({start_o, trip_o}, 0);
    blk_rq <= 0;
    await(0, 1, 30);
    blk_rq <= 1;
    await(0, 0, 30);
    check(trip_o, 0);
    cur_rq <= 16'h0000;
    blk_rq <= 0;
    repeat (30) @(posedge clk_i);
    bus(0, 8'h2c, 0);
    check(r, 32'h5);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_curve();
    t_trip();
    t_block();
    wrap_up();
  end
endmodule // ljp_stage_test
`default_nettype wire
